//--- rtl/sxa_pkg.sv
// Package and interfaces of the subtract, xor and nibble-exchange ALU.
// Assumes one clock domain; all users name items as sxa_pkg::name.
package sxa_pkg;

	localparam int         DATA_W      = 8;
	localparam int         REG_AW      = 7;
	localparam int         BUS_AW      = 8;
	localparam int         REG_DEPTH   = 128;

	// Register port map
	localparam logic [7:0] ACC_ADDR    = 8'h80;
	localparam logic [7:0] STAT_ADDR   = 8'h81;

	// Status field positions
	localparam int         STAT_C_BIT  = 0;
	localparam int         STAT_NB_BIT = 1;
	localparam int         STAT_Z_BIT  = 2;

	// Reset values
	localparam logic [7:0] ACC_RST     = 8'h00;
	localparam logic       FLAG_RST    = 1'b0;
	localparam logic [7:0] RDATA_RST   = 8'h00;

	// Target select
	localparam logic       DEST_ACC    = 1'b0;
	localparam logic       DEST_REG    = 1'b1;

	typedef enum logic [2:0]
	{
		SXA_OP_LIT_SUB,
		SXA_OP_REG_SUB,
		SXA_OP_REG_XOR,
		SXA_OP_SWAP,
		SXA_OP_LIT_XOR
	} sxa_op_t;

	typedef enum logic
	{
		SXA_IDLE,
		SXA_EXEC
	} sxa_state_t;

	// Known operation code
	function automatic logic op_known(input logic [2:0] code);
		return code <= 3'h4;
	endfunction

	// Operation takes a data register operand
	function automatic logic op_uses_reg(input sxa_op_t op);
		return (op == SXA_OP_REG_SUB) || (op == SXA_OP_REG_XOR) || (op == SXA_OP_SWAP);
	endfunction

endpackage

interface sxa_mem_if;
	logic       wr_en;
	logic [6:0] wr_addr;
	logic [7:0] wr_data;
	logic [6:0] ra_addr;
	logic [7:0] ra_data;
	logic [6:0] rb_addr;
	logic       rb_mem_sel;
	logic [7:0] rb_alt;
	logic [7:0] rb_data;

	modport ctrl
	(
		output wr_en, wr_addr, wr_data, ra_addr, rb_addr, rb_mem_sel, rb_alt,
		input  ra_data, rb_data
	);
	modport mem
	(
		input  wr_en, wr_addr, wr_data, ra_addr, rb_addr, rb_mem_sel, rb_alt,
		output ra_data, rb_data
	);
endinterface

interface sxa_calc_if;
	sxa_pkg::sxa_op_t op;
	logic [7:0]       acc;
	logic [7:0]       operand;
	logic [7:0]       result;
	logic             c;
	logic             nb;
	logic             z;
	logic             upd_cz;
	logic             upd_z;

	modport ctrl
	(
		output op, acc, operand,
		input  result, c, nb, z, upd_cz, upd_z
	);
	modport calc
	(
		input  op, acc, operand,
		output result, c, nb, z, upd_cz, upd_z
	);
endinterface

//--- rtl/sxa_regfile.sv
// Data register file: one write port, two registered read ports.
// Assumes writes and reads on ref_clk; read data valid the cycle after.
module sxa_regfile #(
	parameter int DEPTH = sxa_pkg::REG_DEPTH
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Memory port
	sxa_mem_if.mem   mif
);

	logic [7:0] mem_q [DEPTH];
	logic [7:0] ra_r;
	logic [7:0] ra_nxt;
	logic [7:0] rb_r;
	logic [7:0] rb_nxt;

	// Array write
	always_ff @(posedge ref_clk)
	begin
		if (mif.wr_en)
			mem_q[mif.wr_addr] <= mif.wr_data;
	end

	// Read selection
	always_comb
	begin
		ra_nxt = mem_q[mif.ra_addr];
		rb_nxt = mif.rb_mem_sel ? mem_q[mif.rb_addr] : mif.rb_alt;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			ra_r <= sxa_pkg::RDATA_RST;
			rb_r <= sxa_pkg::RDATA_RST;
		end
		else
		begin
			ra_r <= ra_nxt;
			rb_r <= rb_nxt;
		end
	end

	assign mif.ra_data = ra_r;
	assign mif.rb_data = rb_r;

endmodule // sxa_regfile

//--- rtl/sxa_calc.sv
// Combinational result and flag computation for one operation.
// Assumes operands are stable during the execute cycle.
module sxa_calc (
	// Operands and results
	sxa_calc_if.calc cif
);

	always_comb
	begin
		cif.result = 8'h00;
		cif.c      = 1'b0;
		cif.nb     = 1'b0;
		cif.upd_cz = 1'b0;
		cif.upd_z  = 1'b0;
		case (cif.op)
			sxa_pkg::SXA_OP_LIT_SUB, sxa_pkg::SXA_OP_REG_SUB:
			begin
				cif.result = cif.operand - cif.acc;
				cif.c      = cif.acc <= cif.operand;
				cif.nb     = cif.acc[3:0] <= cif.operand[3:0];
				cif.upd_cz = 1'b1;
				cif.upd_z  = 1'b1;
			end
			sxa_pkg::SXA_OP_REG_XOR, sxa_pkg::SXA_OP_LIT_XOR:
			begin
				cif.result = cif.operand ^ cif.acc;
				cif.upd_z  = 1'b1;
			end
			sxa_pkg::SXA_OP_SWAP:
			begin
				cif.result = {cif.operand[3:0], cif.operand[7:4]};
			end
			default:
			begin
			end
		endcase
		cif.z = (cif.result == 8'h00);
	end

endmodule // sxa_calc

//--- rtl/sxa_alu.sv
// Subtract, xor and nibble-exchange ALU with accumulator, flags and registers.
// Assumes one clock, synchronous reset, and a register port master on ref_clk.
//
// Function
// - Literal minus accumulator goes to accumulator
// - Carry and nibble flag mean accumulator not greater
// - Register minus accumulator, flags, addresses 0 to 127
// - Target bit 0 accumulator, 1 register
// - Register xor accumulator, zero flag only
// - Nibble exchange to target, flags unchanged
// - Literal xor accumulator, zero flag only
//
// Chosen here: the placing of the registers and the plain strobed port.
module sxa_alu (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	// Operation request
	input  wire logic       op_valid,
	input  wire logic [2:0] op_code,
	input  wire logic [7:0] op_literal,
	input  wire logic [6:0] op_reg_addr,
	input  wire logic       op_dest_sel,
	// Register port
	input  wire logic [7:0] bus_addr,
	input  wire logic [7:0] bus_wdata,
	input  wire logic       bus_wr,
	input  wire logic       bus_rd,
	output logic      [7:0] bus_rdata,
	// Status
	output logic            op_busy,
	output logic            op_done,
	output logic      [7:0] acc_value,
	output logic            carry_flag,
	output logic            nibble_borrow_not_flag,
	output logic            zero_flag
);

	sxa_mem_if  mif ();
	sxa_calc_if cif ();

	sxa_pkg::sxa_state_t state_r;
	sxa_pkg::sxa_state_t state_nxt;
	sxa_pkg::sxa_op_t    op_r;
	sxa_pkg::sxa_op_t    op_nxt;
	logic [7:0]          lit_r;
	logic [7:0]          lit_nxt;
	logic [6:0]          addr_r;
	logic [6:0]          addr_nxt;
	logic                dest_r;
	logic                dest_nxt;
	logic                busy_r;
	logic                busy_nxt;
	logic                done_r;
	logic                done_nxt;
	logic [7:0]          acc_r;
	logic [7:0]          acc_nxt;
	logic                c_r;
	logic                c_nxt;
	logic                nb_r;
	logic                nb_nxt;
	logic                z_r;
	logic                z_nxt;
	logic                to_reg;

	sxa_regfile #(
		.DEPTH   (sxa_pkg::REG_DEPTH)
	) u_regfile (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.mif     (mif)
	);

	sxa_calc u_calc (
		.cif     (cif)
	);

	// Operand routing
	assign cif.op      = op_r;
	assign cif.acc     = acc_r;
	assign cif.operand = sxa_pkg::op_uses_reg(op_r) ? mif.ra_data : lit_r;
	assign mif.ra_addr = op_reg_addr;
	assign to_reg      = sxa_pkg::op_uses_reg(op_r) && (dest_r == sxa_pkg::DEST_REG);

	// Register port read path
	always_comb
	begin
		mif.rb_addr    = bus_addr[6:0];
		mif.rb_mem_sel = 1'b0;
		mif.rb_alt     = 8'h00;
		if (bus_rd && (bus_addr < sxa_pkg::ACC_ADDR))
			mif.rb_mem_sel = 1'b1;
		else if (bus_rd && (bus_addr == sxa_pkg::ACC_ADDR))
			mif.rb_alt = acc_r;
		else if (bus_rd && (bus_addr == sxa_pkg::STAT_ADDR))
		begin
			mif.rb_alt[sxa_pkg::STAT_C_BIT]  = c_r;
			mif.rb_alt[sxa_pkg::STAT_NB_BIT] = nb_r;
			mif.rb_alt[sxa_pkg::STAT_Z_BIT]  = z_r;
		end
	end

	// Sequencing, write-back and flags
	always_comb
	begin
		state_nxt   = state_r;
		op_nxt      = op_r;
		lit_nxt     = lit_r;
		addr_nxt    = addr_r;
		dest_nxt    = dest_r;
		busy_nxt    = busy_r;
		done_nxt    = 1'b0;
		acc_nxt     = acc_r;
		c_nxt       = c_r;
		nb_nxt      = nb_r;
		z_nxt       = z_r;
		mif.wr_en   = 1'b0;
		mif.wr_addr = bus_addr[6:0];
		mif.wr_data = bus_wdata;
		// Software writes; an operation in the same cycle overrides the flags that it writes and its target, or any register write when it targets a register
		if (bus_wr && (bus_addr < sxa_pkg::ACC_ADDR))
			mif.wr_en = 1'b1;
		else if (bus_wr && (bus_addr == sxa_pkg::ACC_ADDR))
			acc_nxt = bus_wdata;
		else if (bus_wr && (bus_addr == sxa_pkg::STAT_ADDR))
		begin
			c_nxt  = bus_wdata[sxa_pkg::STAT_C_BIT];
			nb_nxt = bus_wdata[sxa_pkg::STAT_NB_BIT];
			z_nxt  = bus_wdata[sxa_pkg::STAT_Z_BIT];
		end
		case (state_r)
			sxa_pkg::SXA_IDLE:
			begin
				if (op_valid && sxa_pkg::op_known(op_code))
				begin
					op_nxt    = sxa_pkg::sxa_op_t'(op_code);
					lit_nxt   = op_literal;
					addr_nxt  = op_reg_addr;
					dest_nxt  = op_dest_sel;
					busy_nxt  = 1'b1;
					state_nxt = sxa_pkg::SXA_EXEC;
				end
			end
			sxa_pkg::SXA_EXEC:
			begin
				busy_nxt  = 1'b0;
				done_nxt  = 1'b1;
				state_nxt = sxa_pkg::SXA_IDLE;
				if (to_reg)
				begin
					mif.wr_en   = 1'b1;
					mif.wr_addr = addr_r;
					mif.wr_data = cif.result;
				end
				else
					acc_nxt = cif.result;
				if (cif.upd_cz)
				begin
					c_nxt  = cif.c;
					nb_nxt = cif.nb;
				end
				if (cif.upd_z)
					z_nxt = cif.z;
			end
			default:
			begin
				state_nxt = sxa_pkg::SXA_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			state_r <= sxa_pkg::SXA_IDLE;
			op_r    <= sxa_pkg::SXA_OP_LIT_SUB;
			lit_r   <= 8'h00;
			addr_r  <= 7'h00;
			dest_r  <= sxa_pkg::DEST_ACC;
			busy_r  <= 1'b0;
			done_r  <= 1'b0;
			acc_r   <= sxa_pkg::ACC_RST;
			c_r     <= sxa_pkg::FLAG_RST;
			nb_r    <= sxa_pkg::FLAG_RST;
			z_r     <= sxa_pkg::FLAG_RST;
		end
		else
		begin
			state_r <= state_nxt;
			op_r    <= op_nxt;
			lit_r   <= lit_nxt;
			addr_r  <= addr_nxt;
			dest_r  <= dest_nxt;
			busy_r  <= busy_nxt;
			done_r  <= done_nxt;
			acc_r   <= acc_nxt;
			c_r     <= c_nxt;
			nb_r    <= nb_nxt;
			z_r     <= z_nxt;
		end
	end

	assign bus_rdata              = mif.rb_data;
	assign op_busy                = busy_r;
	assign op_done                = done_r;
	assign acc_value              = acc_r;
	assign carry_flag             = c_r;
	assign nibble_borrow_not_flag = nb_r;
	assign zero_flag              = z_r;

endmodule // sxa_alu

//--- tb/sxa_alu_chk.sv
// Checker of operation timing, results and flags.
// Assumes binding to sxa_alu; sees its ports only.
module sxa_alu_chk (
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       rst_b,
	// Request
	input wire logic       op_valid,
	input wire logic [2:0] op_code,
	input wire logic [7:0] op_literal,
	input wire logic       op_dest_sel,
	input wire logic       bus_wr,
	// Status
	input wire logic       op_busy,
	input wire logic       op_done,
	input wire logic [7:0] acc_value,
	input wire logic       carry_flag,
	input wire logic       nibble_borrow_not_flag,
	input wire logic       zero_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	logic       tk;
	logic [7:0] a_q;
	logic [7:0] l_q;
	assign tk = op_valid && !op_busy && (op_code <= 3'h4) && !bus_wr;
	always_ff @(posedge ref_clk)
	begin
		if (tk)
		begin
			a_q <= acc_value;
			l_q <= op_literal;
		end
	end
	property p_time; tk |=> op_busy ##1 (op_done && !op_busy); endproperty
	a_time: assert property (p_time) else $error("busy/done timing");
	property p_lsub; tk && op_code == 3'h0 |=> ##1 acc_value == 8'(l_q - a_q); endproperty
	a_lsub: assert property (p_lsub) else $error("literal subtract");
	property p_lflg; tk && op_code == 3'h0 |=> ##1 carry_flag == (a_q <= l_q)
		&& nibble_borrow_not_flag == (a_q[3:0] <= l_q[3:0]); endproperty
	a_lflg: assert property (p_lflg) else $error("subtract flags");
	property p_lxor; tk && op_code == 3'h4 |=> ##1 acc_value == (a_q ^ l_q)
		&& zero_flag == ((a_q ^ l_q) == 8'h00); endproperty
	a_lxor: assert property (p_lxor) else $error("literal xor");
	property p_swap; tk && op_code == 3'h3 ##1 !bus_wr
		|=> $stable({carry_flag, nibble_borrow_not_flag, zero_flag}); endproperty
	a_swap: assert property (p_swap) else $error("swap changed flags");
	property p_xkeep; tk && op_code == 3'h2 ##1 !bus_wr
		|=> $stable({carry_flag, nibble_borrow_not_flag}); endproperty
	a_xkeep: assert property (p_xkeep) else $error("xor changed carry");
	property p_dest; tk && op_code inside {3'h1, 3'h2, 3'h3} && op_dest_sel
		##1 !bus_wr |=> $stable(acc_value); endproperty
	a_dest: assert property (p_dest) else $error("register target hit acc");
	property p_zero; tk && op_code inside {3'h1, 3'h2} && !op_dest_sel
		|=> ##1 zero_flag == (acc_value == 8'h00); endproperty
	a_zero: assert property (p_zero) else $error("zero flag");
endmodule // sxa_alu_chk

bind sxa_alu sxa_alu_chk i_sxa_alu_chk (.ref_clk(ref_clk), .rst_b(rst_b),
	.op_valid(op_valid), .op_code(op_code), .op_literal(op_literal),
	.op_dest_sel(op_dest_sel), .bus_wr(bus_wr), .op_busy(op_busy),
	.op_done(op_done), .acc_value(acc_value), .carry_flag(carry_flag),
	.nibble_borrow_not_flag(nibble_borrow_not_flag), .zero_flag(zero_flag));

//--- tb/sxa_issuer.sv
// Decoder stand-in issuing one operation per call.
// Assumes the ALU is idle when issue is called.
module sxa_issuer (
	// Clock
	input wire logic       ref_clk,
	// Request
	output logic           op_valid = 1'b0,
	output logic     [2:0] op_code = 3'h0,
	output logic     [7:0] op_literal = 8'h00,
	output logic     [6:0] op_reg_addr = 7'h00,
	output logic           op_dest_sel = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	task automatic issue(input logic [2:0] c, input logic [7:0] k,
		input logic [6:0] a, input logic d);
		@(posedge ref_clk);
		op_valid <= 1'b1;
		op_code <= c;
		op_literal <= k;
		op_reg_addr <= a;
		op_dest_sel <= d;
		@(posedge ref_clk);
		op_valid <= 1'b0;
		op_literal <= ~k;
		op_reg_addr <= ~a;
	endtask
endmodule // sxa_issuer

//--- tb/sxa_alu_tb_top.sv
// Self-checking bench: random and corner operations, register port.
// Assumes design, issuer and checker files compiled before it.
module sxa_alu_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       ref_clk = 1'b0, rst_b = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
	logic       op_valid, op_dest_sel, op_busy, op_done, cm, dm, zm;
	logic       carry_flag, nibble_borrow_not_flag, zero_flag;
	logic [2:0] op_code;
	logic [6:0] op_reg_addr;
	logic [7:0] op_literal, bus_rdata, acc_value, acc_m;
	logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00;
	logic [7:0] mem [128];
	int         fails = 0, n_tests = 0, cyc = 0;
	initial forever #2.5 ref_clk = ~ref_clk;
	sxa_issuer i_sxa_issuer (.ref_clk(ref_clk), .op_valid(op_valid), .op_code(op_code),
		.op_literal(op_literal), .op_reg_addr(op_reg_addr), .op_dest_sel(op_dest_sel));
	sxa_alu i_sxa_alu (.ref_clk(ref_clk), .rst_b(rst_b), .op_valid(op_valid),
		.op_code(op_code), .op_literal(op_literal), .op_reg_addr(op_reg_addr),
		.op_dest_sel(op_dest_sel), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .op_busy(op_busy),
		.op_done(op_done), .acc_value(acc_value), .carry_flag(carry_flag),
		.nibble_borrow_not_flag(nibble_borrow_not_flag), .zero_flag(zero_flag));
	task automatic final_report;
		$display("Checks %0d, errors %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] res(input logic [2:0] c, input logic [7:0] a, m);
		case (c)
			3'h0, 3'h1: return m - a;
			3'h3: return {m[3:0], m[7:4]};
			default: return m ^ a;
		endcase
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge ref_clk);
		bus_wr <= 1'b0;
		bus_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge ref_clk);
		bus_rd <= 1'b0;
		#1 chk(bus_rdata, e);
	endtask
	task automatic ex(input logic [2:0] c, input logic [7:0] k, input logic [6:0] a,
		input logic d);
		logic [7:0] m;
		logic [7:0] r;
		m = (c == 3'h0 || c == 3'h4) ? k : mem[a];
		r = res(c, acc_m, m);
		if (c < 3'h2)
		begin
			cm = acc_m <= m;
			dm = acc_m[3:0] <= m[3:0];
		end
		if (c != 3'h3)
			zm = r == 8'h00;
		if (d && c inside {3'h1, 3'h2, 3'h3})
			mem[a] = r;
		else
			acc_m = r;
		i_sxa_issuer.issue(c, k, a, d);
		@(posedge ref_clk);
		#1 chk({7'h00, op_done}, 8'h01);
		chk(acc_value, acc_m);
		chk({5'h00, zero_flag, nibble_borrow_not_flag, carry_flag}, {5'h00, zm, dm, cm});
		if (d && c != 3'h0 && c != 3'h4)
			rd({1'b0, a}, mem[a]);
	endtask
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc > 5000)
		begin
			fails++;
			final_report;
		end
	end
	initial
	begin
		void'($urandom(62198));
		{acc_m, cm, dm, zm} = '0;
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		#1 chk(acc_value, 8'h00);
		for (int i = 0; i < 128; i++)
		begin
			mem[i] = 8'($urandom);
			wr(8'(i), mem[i]);
		end
		rd(8'h82, 8'h00);
		wr(8'h81, 8'h07);
		rd(8'h81, 8'h07);
		wr(8'h81, 8'h00);
		rd(8'h81, 8'h00);
		wr(8'h80, 8'h5a);
		acc_m = 8'h5a;
		ex(3'h0, 8'h5a, 7'h00, 1'b0);
		ex(3'h1, 8'h00, 7'h7f, 1'b1);
		ex(3'h3, 8'h00, 7'h00, 1'b1);
		ex(3'h2, 8'h00, 7'h01, 1'b0);
		repeat (60) ex(3'($urandom_range(4)), 8'($urandom), 7'($urandom), 1'($urandom));
		rd(8'h81, {5'h00, zm, dm, cm});
		rd(8'h80, acc_m);
		i_sxa_issuer.issue(3'h5, 8'h00, 7'h00, 1'b0);
		#1 chk({7'h00, op_busy}, 8'h00);
		final_report;
	end
endmodule // sxa_alu_tb_top
